// *** verilog/acrr_defs.svh ***
// Register offsets, field positions, reset values and timing counts for the clock/range block
`ifndef ACRR_DEFS_SVH
`define ACRR_DEFS_SVH
`define ACRR_ADDR_W 12
`define ACRR_CFG1_OFS 12'h000
`define ACRR_CLKCFG_OFS 12'h004
`define ACRR_OSR_OFS 12'h008
`define ACRR_STAT_OFS 12'h00c
`define ACRR_CFG1_REFRNG_BIT 0
`define ACRR_CFG1_INRNG_BIT 1
`define ACRR_CLK_SRC_BIT 0
`define ACRR_CLK_DIV8_BIT 1
`define ACRR_CLK_LOWSPD_BIT 2
`define ACRR_STAT_SAT_BIT 0
`define ACRR_STAT_EFF2X_BIT 1
`define ACRR_STAT_EXT_BIT 2
`define ACRR_STAT_BLANK_BIT 3
`define ACRR_STAT_PEND_BIT 4
`define ACRR_OSR_RST 13'h0020
`define ACRR_OSR_W 13
`define ACRR_MCLK_NS 4
`define ACRR_CORE_HS_KHZ 25600
`define ACRR_CORE_LS_KHZ 3200
`define ACRR_NCO_W 24
`define ACRR_NCO_HS_INC 24'h1a36e3
`define ACRR_NCO_LS_INC 24'h0346dc
`define ACRR_DIV8_LAST 3'h7
`define ACRR_BLANK_US 150
`define ACRR_BLANK_CYCLES ((`ACRR_BLANK_US * 1000 + `ACRR_MCLK_NS - 1) / `ACRR_MCLK_NS)
`endif

// *** verilog/acrr_pkg.sv ***
// Types shared by the clock/range block
package acrr_pkg;
   // Clock configuration as written by software and as applied
   typedef struct packed {
      logic low_speed;
      logic div8_en;
      logic src_sel;
   } acrr_clk_cfg_s;
   // Clock switch sequencing
   typedef enum logic [0:0] {
      SW_IDLE,
      SW_WAIT
   } acrr_sw_e;
endpackage

// *** verilog/acrr_ctrl.sv ***
// Clock source select, dividers, reference range and saturation flag with APB registers
`timescale 1ns/1ps
`include "acrr_defs.svh"
module acrr_ctrl #(
   parameter int unsigned OSR_W = `ACRR_OSR_W,
   parameter int unsigned BLANK_CYCLES = `ACRR_BLANK_CYCLES
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ACRR_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ext_clk_pin,
   input wire logic start_pin,
   input wire logic reset_pin,
   input wire logic mod_saturated,
   output logic core_clk_en,
   output logic mod_clk_en,
   output logic data_ready,
   output logic eff_input_2x,
   output logic clk_src_ext,
   output logic start_ctrl,
   output logic reset_ctrl
);

   // Blanking counter width follows the (shortenable) blanking length
   localparam int unsigned BLANK_W = $clog2(BLANK_CYCLES + 1);
   // Refuse settings the logic cannot serve
   generate
      if (OSR_W < 2 || OSR_W > 16) begin : g_bad_osr
         $error("OSR_W must lie between 2 and 16");
      end
      if (BLANK_CYCLES < 1) begin : g_bad_blank
         $error("BLANK_CYCLES must be at least one");
      end
   endgenerate
   // Software-visible state
   logic ref_range_sel_r; // High reference range when set
   logic input_range_r; // Programmed 2x input range
   acrr_pkg::acrr_clk_cfg_s clk_cfg_r; // Clock setting as written
   acrr_pkg::acrr_clk_cfg_s act_cfg_r; // Clock setting in force
   logic [OSR_W-1:0] oversampling_ratio_r; // Modulator ticks per conversion
   logic mod_saturation_flag_r; // Saturation result of last conversion
   // Clock path state
   acrr_pkg::acrr_sw_e sw_state_r; // Switch sequencer
   logic [`ACRR_NCO_W-1:0] nco_acc_r; // Oscillator phase accumulator
   logic [2:0] div8_cnt_r; // External edge counter for divide by eight
   logic mod_ph_r; // Second half of modulator period
   logic [OSR_W-1:0] conv_cnt_r; // Modulator ticks in current conversion
   logic sat_acc_r; // Saturation seen so far in this conversion
   logic [BLANK_W-1:0] blank_cnt_r; // Control pin blanking time left
   logic sw_gap_r; // Cycle after a switch: new source may not tick yet
   // Pin synchronisers: bit 0 clock, 1 start, 2 reset
   logic [2:0] pin_in;
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic ext_prev_r; // Previous synchronised clock level for edges
   // APB state
   logic pready_r;
   logic [31:0] prdata_r;
   logic pslverr_r;
   // Output flops
   logic core_clk_en_r;
   logic mod_clk_en_r;
   logic data_ready_r;
   logic eff_input_2x_r;
   logic start_ctrl_r;
   logic reset_ctrl_r;

   // Combinational helpers
   logic apb_acc;
   logic apb_fire;
   logic wr_fire;
   logic addr_hit;
   logic [31:0] rd_nxt;
   logic ext_rise;
   logic ext_tick;
   logic [`ACRR_NCO_W:0] nco_sum;
   logic [`ACRR_NCO_W-1:0] nco_inc;
   logic nco_tick;
   logic core_tick;
   logic mod_tick;
   logic old_src_edge;
   logic mode_change;
   logic conv_done;
   logic blanking;
   assign pin_in = {reset_pin, start_pin, ext_clk_pin};
   // Two flops per pin; the first is read only by the second
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_sync
         always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
               sync1_r[gi] <= 1'b0;
               sync2_r[gi] <= 1'b0;
            end else begin
               sync1_r[gi] <= pin_in[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   // Edge history of the synchronised external clock
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ext_prev_r <= 1'b0;
      end else begin
         ext_prev_r <= sync2_r[0];
      end
   end

   // APB: every access waits one cycle, so pready and read data come from flops
   assign apb_acc = psel & penable;
   assign apb_fire = apb_acc & pready_r;
   assign wr_fire = apb_fire & pwrite & addr_hit;
   // Address decode and read mux
   always_comb begin
      rd_nxt = 32'h0000_0000;
      addr_hit = 1'b1;
      case (paddr)
         `ACRR_CFG1_OFS: begin
            rd_nxt[`ACRR_CFG1_REFRNG_BIT] = ref_range_sel_r;
            rd_nxt[`ACRR_CFG1_INRNG_BIT] = input_range_r;
         end
         `ACRR_CLKCFG_OFS: begin
            rd_nxt[`ACRR_CLK_SRC_BIT] = clk_cfg_r.src_sel;
            rd_nxt[`ACRR_CLK_DIV8_BIT] = clk_cfg_r.div8_en;
            rd_nxt[`ACRR_CLK_LOWSPD_BIT] = clk_cfg_r.low_speed;
         end
         `ACRR_OSR_OFS: begin
            rd_nxt[OSR_W-1:0] = oversampling_ratio_r;
         end
         `ACRR_STAT_OFS: begin
            rd_nxt[`ACRR_STAT_SAT_BIT] = mod_saturation_flag_r;
            rd_nxt[`ACRR_STAT_EFF2X_BIT] = eff_input_2x_r;
            rd_nxt[`ACRR_STAT_EXT_BIT] = act_cfg_r.src_sel;
            rd_nxt[`ACRR_STAT_BLANK_BIT] = blanking;
            rd_nxt[`ACRR_STAT_PEND_BIT] = (sw_state_r == acrr_pkg::SW_WAIT);
         end
         default: begin
            addr_hit = 1'b0; // Unmapped: error answer, reads zero
         end
      endcase
   end

   // APB answer timing and read capture
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pready_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         pslverr_r <= 1'b0;
      end else begin
         pready_r <= apb_acc & ~pready_r;
         if (apb_acc && !pready_r) begin
            prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
            pslverr_r <= ~addr_hit;
         end else begin
            pslverr_r <= 1'b0;
         end
      end
   end

   // Configuration registers, written only at the completing APB edge
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ref_range_sel_r <= 1'b0;
         input_range_r <= 1'b0;
         clk_cfg_r <= '0; // Internal oscillator after reset
         oversampling_ratio_r <= OSR_W'(`ACRR_OSR_RST);
      end else if (wr_fire) begin
         case (paddr)
            `ACRR_CFG1_OFS: begin
               ref_range_sel_r <= pwdata[`ACRR_CFG1_REFRNG_BIT];
               input_range_r <= pwdata[`ACRR_CFG1_INRNG_BIT];
            end
            `ACRR_CLKCFG_OFS: begin
               clk_cfg_r.src_sel <= pwdata[`ACRR_CLK_SRC_BIT];
               clk_cfg_r.div8_en <= pwdata[`ACRR_CLK_DIV8_BIT];
               clk_cfg_r.low_speed <= pwdata[`ACRR_CLK_LOWSPD_BIT];
            end
            `ACRR_OSR_OFS: begin
               oversampling_ratio_r <= pwdata[OSR_W-1:0];
            end
            default: begin
               // Status is read-only
            end
         endcase
      end
   end

   // High reference forces 1x whatever the programmed range
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         eff_input_2x_r <= 1'b0;
      end else begin
         eff_input_2x_r <= input_range_r & ~ref_range_sel_r;
      end
   end

   // Internal oscillator: fractional accumulator picks the nominal rate per speed mode
   assign nco_inc = act_cfg_r.low_speed ? `ACRR_NCO_LS_INC : `ACRR_NCO_HS_INC;
   assign nco_sum = {1'b0, nco_acc_r} + {1'b0, nco_inc};
   assign nco_tick = nco_sum[`ACRR_NCO_W];
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         nco_acc_r <= '0;
      end else begin
         nco_acc_r <= nco_sum[`ACRR_NCO_W-1:0];
      end
   end

   // External clock: rising edges, optionally one in eight
   assign ext_rise = sync2_r[0] & ~ext_prev_r;
   assign ext_tick = ext_rise & (~act_cfg_r.div8_en | (div8_cnt_r == `ACRR_DIV8_LAST));
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         div8_cnt_r <= 3'h0;
      end else if (old_src_edge && sw_state_r == acrr_pkg::SW_WAIT) begin
         div8_cnt_r <= 3'h0; // Fresh divide phase for the new setting
      end else if (ext_rise) begin
         div8_cnt_r <= div8_cnt_r + 3'h1;
      end
   end

   // Core tick follows whatever source is in force; a slower pin slows everything
   // The old source ticked at the switch edge, so a new tick right after it would be a runt
   assign core_tick = (act_cfg_r.src_sel ? ext_tick : nco_tick) & ~sw_gap_r;
   assign mod_tick = core_tick & mod_ph_r;
   // Switch only on a raw edge of the old source so no short period leaks out
   assign old_src_edge = act_cfg_r.src_sel ? ext_rise : nco_tick;
   assign mode_change = (sw_state_r == acrr_pkg::SW_WAIT) && old_src_edge &&
                        ((clk_cfg_r.src_sel != act_cfg_r.src_sel) ||
                         (clk_cfg_r.div8_en != act_cfg_r.div8_en));
   // Sequencer: a write is seen one cycle after it completes, applied at an old edge
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sw_state_r <= acrr_pkg::SW_IDLE;
         act_cfg_r <= '0;
         sw_gap_r <= 1'b0;
      end else begin
         sw_gap_r <= mode_change;
         case (sw_state_r)
            acrr_pkg::SW_IDLE: begin
               if (clk_cfg_r != act_cfg_r) begin
                  sw_state_r <= acrr_pkg::SW_WAIT;
               end
            end
            acrr_pkg::SW_WAIT: begin
               // Leaving the pin relies on it toggling a while longer
               if (old_src_edge) begin
                  act_cfg_r <= clk_cfg_r;
                  sw_state_r <= acrr_pkg::SW_IDLE;
               end
            end
            default: begin
               sw_state_r <= acrr_pkg::SW_IDLE;
            end
         endcase
      end
   end

   // Modulator phase restarts with a new source
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mod_ph_r <= 1'b0;
      end else if (mode_change) begin
         mod_ph_r <= 1'b0;
      end else if (core_tick) begin
         mod_ph_r <= ~mod_ph_r;
      end
   end

   // Conversion period: oversampling_ratio modulator ticks; zero acts as one
   assign conv_done = mod_tick &&
      (({1'b0, conv_cnt_r} + {{OSR_W{1'b0}}, 1'b1}) >= {1'b0, oversampling_ratio_r});
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         conv_cnt_r <= '0;
      end else if (conv_done) begin
         conv_cnt_r <= '0;
      end else if (mod_tick) begin
         conv_cnt_r <= conv_cnt_r + OSR_W'(1);
      end
   end

   // Saturation: gather over the period, publish at its end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         sat_acc_r <= 1'b0;
         mod_saturation_flag_r <= 1'b0;
      end else if (conv_done) begin
         // A hit on the closing cycle still counts for the period ending now
         mod_saturation_flag_r <= sat_acc_r | mod_saturated;
         sat_acc_r <= 1'b0;
      end else if (mod_saturated) begin
         sat_acc_r <= 1'b1;
      end
   end

   // Blanking after a source or divider change covers oscillator start-up
   assign blanking = (blank_cnt_r != '0);
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         blank_cnt_r <= '0;
      end else if (mode_change) begin
         blank_cnt_r <= BLANK_W'(BLANK_CYCLES);
      end else if (blanking) begin
         blank_cnt_r <= blank_cnt_r - BLANK_W'(1);
      end
   end

   // Control pins pass through once synchronised, held low while blanked
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         start_ctrl_r <= 1'b0;
         reset_ctrl_r <= 1'b0;
      end else begin
         start_ctrl_r <= sync2_r[1] & ~blanking;
         reset_ctrl_r <= sync2_r[2] & ~blanking;
      end
   end

   // Registered strobes toward the converter core
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         core_clk_en_r <= 1'b0;
         mod_clk_en_r <= 1'b0;
         data_ready_r <= 1'b0;
      end else begin
         core_clk_en_r <= core_tick;
         mod_clk_en_r <= mod_tick;
         data_ready_r <= conv_done;
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign core_clk_en = core_clk_en_r;
   assign mod_clk_en = mod_clk_en_r;
   assign data_ready = data_ready_r;
   assign eff_input_2x = eff_input_2x_r;
   assign clk_src_ext = act_cfg_r.src_sel;
   assign start_ctrl = start_ctrl_r;
   assign reset_ctrl = reset_ctrl_r;

endmodule

// *** bench/acrr_ctrl_props.sv ***
// Port-level assertions for the clock and range controller
`timescale 1ns/1ps
`include "acrr_defs.svh"
module acrr_ctrl_props #(
   parameter int unsigned OSR_W = `ACRR_OSR_W,
   parameter int unsigned BLANK_CYCLES = `ACRR_BLANK_CYCLES
) (
   input wire logic mclk,
   input wire logic arst_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ACRR_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic ext_clk_pin,
   input wire logic start_pin,
   input wire logic reset_pin,
   input wire logic mod_saturated,
   input wire logic core_clk_en,
   input wire logic mod_clk_en,
   input wire logic data_ready,
   input wire logic eff_input_2x,
   input wire logic clk_src_ext,
   input wire logic start_ctrl,
   input wire logic reset_ctrl
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // Write taken at this edge
   wire logic wr_done = psel && penable && pready && pwrite;
   one_wait_a: assert property (psel && !penable |=> !pready ##1 pready ##1 !pready)
      else $error("pready not in second access cycle");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   rst_internal_a: assert property ($rose(arst_n) |-> !clk_src_ext)
      else $error("external source after reset");
   range_2x_a: assert property (
      wr_done && paddr == `ACRR_CFG1_OFS && pwdata[1:0] == 2'h2 |-> ##2 eff_input_2x)
      else $error("2x range not applied");
   ref_force_a: assert property (
      wr_done && paddr == `ACRR_CFG1_OFS && pwdata[0] |-> ##2 !eff_input_2x)
      else $error("2x range kept with high reference");
   apply_late_a: assert property (
      wr_done && paddr == `ACRR_CLKCFG_OFS |=> $stable(clk_src_ext))
      else $error("source switched inside the write");
   blank_ctl_a: assert property (
      $changed(clk_src_ext) |-> ##2 (!start_ctrl && !reset_ctrl) [*8])
      else $error("control pin passed while blanking");
   core_gap_a: assert property (core_clk_en |=> !core_clk_en)
      else $error("core ticks back to back");
   mod_half_a: assert property (mod_clk_en |=> !mod_clk_en [*3])
      else $error("modulator tick closer than two core ticks");
   conv_gap_a: assert property (data_ready |=> !data_ready)
      else $error("conversion ends back to back");
endmodule
bind acrr_ctrl acrr_ctrl_props #(.OSR_W(OSR_W), .BLANK_CYCLES(BLANK_CYCLES)) acrr_ctrl_props_i (
   .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .ext_clk_pin(ext_clk_pin), .start_pin(start_pin), .reset_pin(reset_pin),
   .mod_saturated(mod_saturated), .core_clk_en(core_clk_en), .mod_clk_en(mod_clk_en),
   .data_ready(data_ready), .eff_input_2x(eff_input_2x), .clk_src_ext(clk_src_ext),
   .start_ctrl(start_ctrl), .reset_ctrl(reset_ctrl)
);

// *** bench/acrr_host_model.sv ***
// Host-side clock source feeding the converter's external clock pin
`timescale 1ns/1ps
module acrr_host_model (
   input wire logic run,
   input wire logic [7:0] half_ns,
   output logic ext_clk_pin
);
   // Pin rests low between bursts; the host starts it before selecting it
   // and keeps it running well past a switch back to the oscillator
   initial begin
      ext_clk_pin = 1'b0;
      forever begin
         if (run === 1'b1) begin
            #(half_ns) ext_clk_pin = 1'b1;
            #(half_ns) ext_clk_pin = 1'b0;
         end else begin
            @(posedge run);
            #1; // Keeps pin edges away from the converter's sampling edge
         end
      end
   end
endmodule

// *** bench/acrr_ctrl_tb.sv ***
// Self-checking bench for the clock and range controller
`timescale 1ns/1ps
`include "acrr_defs.svh"
module acrr_ctrl_tb;
   localparam int BLANK = 20; // Short blanking keeps the run brief
   logic mclk, arst_n, psel, penable, pwrite, start_pin, reset_pin, mod_saturated;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, er, ext_clk_pin, ext_run;
   logic core_clk_en, mod_clk_en, data_ready, eff_input_2x, clk_src_ext, start_ctrl, reset_ctrl;
   logic [7:0] ext_half;
   int n_fail, cmp_count, nc, nm, nd;
   acrr_ctrl #(.BLANK_CYCLES(BLANK)) acrr_ctrl_i (
      .mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .ext_clk_pin(ext_clk_pin), .start_pin(start_pin), .reset_pin(reset_pin),
      .mod_saturated(mod_saturated), .core_clk_en(core_clk_en), .mod_clk_en(mod_clk_en),
      .data_ready(data_ready), .eff_input_2x(eff_input_2x), .clk_src_ext(clk_src_ext),
      .start_ctrl(start_ctrl), .reset_ctrl(reset_ctrl)
   );
   acrr_host_model acrr_host_model_i (.run(ext_run), .half_ns(ext_half), .ext_clk_pin(ext_clk_pin));
   // Verdict and end of run
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string nm_s, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm_s, e, g);
      end
   endtask
   // Tick counts drift by a tick at window edges, so allow a tolerance
   task automatic near(input string nm_s, input int e, input int g, input int t);
      cmp_count++;
      if (g < e - t || g > e + t) begin
         n_fail++;
         $display("[ERR] %s expected %0d seen %0d", nm_s, e, g);
      end
   endtask
   // One APB transfer; entered and left just after a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
      if (k >= 20) begin
         n_fail++;
         test_done();
      end
   endtask
   task automatic rdchk(input string nm_s, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm_s, e, rd);
   endtask
   // Count pulses of the rate outputs over a window
   task automatic cnt(input int n);
      nc = 0;
      nm = 0;
      nd = 0;
      repeat (n) begin
         @(posedge mclk);
         nc += int'(core_clk_en === 1'b1);
         nm += int'(mod_clk_en === 1'b1);
         nd += int'(data_ready === 1'b1);
      end
   endtask
   task automatic wait_sig(input int which, input logic v);
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while ((which ? data_ready : clk_src_ext) !== v && k < 600);
      if (k >= 600) begin
         n_fail++;
         test_done();
      end
   endtask
   task automatic t_reset();
      rdchk("status", `ACRR_STAT_OFS, 32'h0);
      rdchk("clkcfg", `ACRR_CLKCFG_OFS, 32'h0);
      rdchk("unmapped", 12'h010, 32'h0);
      chk("slverr", 1, er);
   endtask
   task automatic t_range();
      apb(1'b1, `ACRR_CFG1_OFS, 32'h2);
      @(posedge mclk);
      chk("eff 2x", 1, eff_input_2x);
      apb(1'b1, `ACRR_CFG1_OFS, 32'h3);
      @(posedge mclk);
      chk("eff forced", 0, eff_input_2x);
      rdchk("cfg1", `ACRR_CFG1_OFS, 32'h3);
   endtask
   // Internal oscillator rates in both speed modes, with a short ratio
   task automatic t_rate();
      apb(1'b1, `ACRR_OSR_OFS, 32'h4);
      cnt(1000);
      near("core hs", 1000 * `ACRR_MCLK_NS * `ACRR_CORE_HS_KHZ / 1000000, nc, 2);
      near("mod", nc / 2, nm, 1);
      near("conv", nm / 4, nd, 1);
      apb(1'b1, `ACRR_CLKCFG_OFS, 32'h4);
      cnt(2000);
      near("core ls", 2000 * `ACRR_MCLK_NS * `ACRR_CORE_LS_KHZ / 1000000, nc, 2);
      apb(1'b1, `ACRR_CLKCFG_OFS, 32'h0);
   endtask
   task automatic t_sat();
      wait_sig(1, 1'b1);
      mod_saturated <= 1'b1;
      @(posedge mclk);
      mod_saturated <= 1'b0;
      wait_sig(1, 1'b1);
      apb(1'b0, `ACRR_STAT_OFS, 32'h0);
      chk("sat set", 1, rd[`ACRR_STAT_SAT_BIT]);
      wait_sig(1, 1'b1);
      apb(1'b0, `ACRR_STAT_OFS, 32'h0);
      chk("sat clear", 0, rd[`ACRR_STAT_SAT_BIT]);
   endtask
   // External clock: switch, blanking, divide by eight, slow clock, return
   task automatic t_ext();
      ext_half <= 8'd20;
      ext_run <= 1'b1;
      repeat (20) @(posedge mclk);
      chk("start open", 1, start_ctrl);
      apb(1'b1, `ACRR_CLKCFG_OFS, 32'h1);
      wait_sig(0, 1'b1);
      repeat (3) @(posedge mclk);
      chk("start blank", 0, start_ctrl);
      chk("reset blank", 0, reset_ctrl);
      rdchk("status blank", `ACRR_STAT_OFS, 32'h0000_000c);
      repeat (BLANK + 6) @(posedge mclk);
      chk("start again", 1, start_ctrl);
      chk("reset again", 1, reset_ctrl);
      cnt(400);
      near("core ext", 400 * `ACRR_MCLK_NS / 40, nc, 2);
      apb(1'b1, `ACRR_CLKCFG_OFS, 32'h3);
      cnt(800);
      near("core div8", 800 * `ACRR_MCLK_NS / 320, nc, 2);
      ext_half <= 8'd40;
      apb(1'b1, `ACRR_CLKCFG_OFS, 32'h1);
      cnt(800);
      near("core slow", 800 * `ACRR_MCLK_NS / 80, nc, 2);
      apb(1'b1, `ACRR_CLKCFG_OFS, 32'h0);
      wait_sig(0, 1'b0);
      repeat (100) @(posedge mclk);
      ext_run <= 1'b0;
   endtask
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   initial begin
      {arst_n, psel, penable, pwrite, mod_saturated, ext_run} = 6'h0;
      {start_pin, reset_pin} = 2'h3;
      paddr = 12'h000;
      pwdata = 32'h0;
      ext_half = 8'd20;
      n_fail = 0;
      cmp_count = 0;
      repeat (10) @(posedge mclk);
      arst_n <= 1'b1;
      t_reset();
      t_range();
      t_rate();
      t_sat();
      t_ext();
      test_done();
   end
endmodule
